// >>> dmm_decode.sv
`timescale 1ns/10ps
`default_nettype none
module dmm_decode
  import dmm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] phase,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic [7:0] mem_rdata,
  output var dmm_pkg::dmm_mem_req_t mem_req,
  output var dmm_pkg::dmm_arch_t arch,
  output logic busy,
  output logic instr_done
);
  import dmm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE_WAIT, ST_MOVE_WRITE} dmm_state_t;

  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  dmm_state_t state_q;
  dmm_state_t state_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [7:0] bank_q;
  logic [7:0] bank_d;
  logic [7:0] prod_hi_q;
  logic [7:0] prod_hi_d;
  logic [7:0] prod_lo_q;
  logic [7:0] prod_lo_d;
  logic [7:0] move_data_q;
  logic [7:0] move_data_d;
  logic [11:0] move_src_q;
  logic [11:0] move_src_d;
  dmm_mem_req_t req_q;
  dmm_mem_req_t req_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic [15:0] product;
  logic [11:0] file_addr;
  // Decoded instruction flags, raised only for a word offered in phase one.
  logic dec_move_src;
  logic dec_move_dst;
  logic dec_load_bank;
  logic dec_load_acc;
  logic dec_mul_lit;
  logic dec_store_acc;
  // The held move address names the working register.
  logic move_at_acc;

  // Reset is released through two flip-flops.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // Unsigned product of working register and literal.
  assign product = acc_q * instr[7:0];

  // Banked file address for single-word file instructions.
  always_comb
  begin
    if (instr[8])
    begin
      file_addr = {bank_q[3:0], instr[7:0]};
    end
    else if (instr[7:0] < ACCESS_SPLIT)
    begin
      file_addr = {4'h0, instr[7:0]};
    end
    else
    begin
      file_addr = {ACCESS_HIGH_BANK, instr[7:0]};
    end
  end

  // The working register is not on the data bus, so the move reaches it directly.
  assign move_at_acc = (move_src_q == ADDR_ACC);

  // Opcode decode: one flag per instruction word handled by this block.
  // A word counts only while it is offered in phase one.
  always_comb
  begin
    dec_move_src = 1'b0;
    dec_move_dst = 1'b0;
    dec_load_bank = 1'b0;
    dec_load_acc = 1'b0;
    dec_mul_lit = 1'b0;
    dec_store_acc = 1'b0;
    if (instr_valid && phase == PH_Q1)
    begin
      // The patterns do not overlap, so at most one flag is raised.
      dec_move_src = (instr[15:12] == OP_MOVE_SRC);
      dec_move_dst = (instr[15:12] == OP_MOVE_DST);
      dec_load_bank = (instr[15:8] == OP_LOAD_BANK);
      dec_load_acc = (instr[15:8] == OP_LOAD_ACC);
      dec_mul_lit = (instr[15:8] == OP_MUL_LIT);
      dec_store_acc = (instr[15:9] == OP_STORE_ACC);
    end
  end

  // Decode and execute: next values of every architectural register.
  // No status flag exists here, so none of these instructions can touch one.
  always_comb
  begin
    state_d = state_q;
    acc_d = acc_q;
    bank_d = bank_q;
    prod_hi_d = prod_hi_q;
    prod_lo_d = prod_lo_q;
    move_data_d = move_data_q;
    move_src_d = move_src_q;
    req_d = '0;
    busy_d = busy_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        // Unknown words leave every register alone.
        // Only one instruction starts per instruction cycle.
        if (dec_move_src)
        begin
          // First move word: the source is read while phase two stands.
          move_src_d = instr[11:0];
          req_d.rd = 1'b1;
          req_d.addr = instr[11:0];
          busy_d = 1'b1;
          state_d = ST_MOVE_WAIT;
        end
        else if (dec_load_bank)
        begin
          // All eight literal bits are kept.
          // File addressing uses only the low four of them.
          bank_d = instr[7:0];
          done_d = 1'b1;
        end
        else if (dec_load_acc)
        begin
          acc_d = instr[7:0];
          done_d = 1'b1;
        end
        else if (dec_mul_lit)
        begin
          // The working register is only read, so it keeps its value.
          // An eight by eight product always fits the sixteen-bit pair.
          prod_hi_d = product[15:8];
          prod_lo_d = product[7:0];
          done_d = 1'b1;
        end
        else if (dec_store_acc)
        begin
          // The access bit and bank page are resolved in file_addr.
          req_d.wr = 1'b1;
          req_d.addr = file_addr;
          req_d.wdata = acc_q;
          done_d = 1'b1;
        end
      end

      ST_MOVE_WAIT:
      begin
        // Take the source byte once, in the cycle after the read request.
        // Later phase-two cycles must not overwrite it while word two is awaited.
        if (req_q.rd)
        begin
          move_data_d = move_at_acc ? acc_q : mem_rdata;
        end
        // Any word other than the destination word is ignored here.
        if (dec_move_dst)
        begin
          move_src_d = instr[11:0];
          state_d = ST_MOVE_WRITE;
        end
      end

      ST_MOVE_WRITE:
      begin
        // Destination latched at the end of phase one of the second cycle; the bus write request shows in the next phase one; no flags touched.
        // Protected destinations are written like any other; their result is undefined.
        if (phase == PH_Q4)
        begin
          if (move_at_acc)
          begin
            acc_d = move_data_q;
          end
          else
          begin
            req_d.wr = 1'b1;
            req_d.addr = move_src_q;
            req_d.wdata = move_data_q;
          end
          busy_d = 1'b0;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end

      default:
      begin
        // An unused state code falls back to idle and drops busy.
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // Architectural registers.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Every register returns to its reset value.
      acc_q <= RST_ACC;
      bank_q <= RST_BANK;
      prod_hi_q <= RST_PROD;
      prod_lo_q <= RST_PROD;
    end
    else
    begin
      // Take the next values.
      acc_q <= acc_d;
      bank_q <= bank_d;
      prod_hi_q <= prod_hi_d;
      prod_lo_q <= prod_lo_d;
    end
  end

  // Move sequencing registers.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // A reset abandons any move in progress.
      state_q <= ST_IDLE;
      move_data_q <= 8'h00;
      move_src_q <= 12'h000;
      busy_q <= 1'b0;
    end
    else
    begin
      // Take the next values.
      state_q <= state_d;
      move_data_q <= move_data_d;
      move_src_q <= move_src_d;
      busy_q <= busy_d;
    end
  end

  // Data bus request and completion pulse registers.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // No request and no completion while in reset.
      req_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      // Both are one-cycle pulses built afresh each cycle.
      req_q <= req_d;
      done_q <= done_d;
    end
  end

  // Outputs straight from flip-flops.
  assign mem_req = req_q;
  assign arch = {acc_q, bank_q, prod_hi_q, prod_lo_q};
  assign busy = busy_q;
  assign instr_done = done_q;
endmodule
`default_nettype wire

// >>> dmm_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module dmm_monitor
  import dmm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] phase,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire dmm_pkg::dmm_mem_req_t mem_req,
  input wire dmm_pkg::dmm_arch_t arch,
  input wire logic busy,
  input wire logic instr_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic tk;
  // An instruction word is taken in idle at phase one.
  assign tk = instr_valid && phase == PH_Q1 && !busy;
  bank_load_a: assert property (tk && instr[15:8] == OP_LOAD_BANK |=> instr_done
    && arch.bank == $past(instr[7:0])) else $error("bank load wrong");
  acc_load_a: assert property (tk && instr[15:8] == OP_LOAD_ACC |=>
    arch.acc == $past(instr[7:0])) else $error("accumulator load wrong");
  mul_prod_a: assert property (tk && instr[15:8] == OP_MUL_LIT |=>
    {arch.prod_hi, arch.prod_lo} == $past(arch.acc) * $past(instr[7:0]))
    else $error("product wrong");
  mul_keep_a: assert property (tk && instr[15:8] == OP_MUL_LIT |=> $stable(arch.acc))
    else $error("multiply changed accumulator");
  store_write_a: assert property (tk && instr[15:9] == OP_STORE_ACC |=> mem_req.wr
    && mem_req.wdata == $past(arch.acc) && mem_req.addr[7:0] == $past(instr[7:0]))
    else $error("store write wrong");
  bank_sel_a: assert property (tk && instr[15:9] == OP_STORE_ACC |=> mem_req.addr[11:8] ==
    ($past(instr[8]) ? $past(arch.bank[3:0]) : {4{$past(instr[7])}}))
    else $error("store bank wrong");
  move_read_a: assert property (tk && instr[15:12] == OP_MOVE_SRC |=> mem_req.rd && busy
    && mem_req.addr == $past(instr[11:0])) else $error("move read wrong");
  move_end_a: assert property ($fell(busy) |-> instr_done && $past(phase) == PH_Q4)
    else $error("move end wrong");
  cover property (tk && instr[15:12] == OP_MOVE_SRC);
  cover property (tk && instr[15:8] == OP_MUL_LIT);
  cover property (tk && instr[15:9] == OP_STORE_ACC && instr[8]);
endmodule
bind dmm_decode dmm_monitor dmm_monitor_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .phase(phase), .instr(instr), .instr_valid(instr_valid), .mem_req(mem_req),
  .arch(arch), .busy(busy), .instr_done(instr_done));
`default_nettype wire

// >>> dmm_pkg.sv
package dmm_pkg;
  // Instruction word and data space geometry.
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // Opcode patterns.
  localparam logic [3:0] OP_MOVE_SRC = 4'h0c;
  localparam logic [3:0] OP_MOVE_DST = 4'h0f;
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam logic [7:0] OP_LOAD_ACC = 8'h0e;
  localparam logic [7:0] OP_MUL_LIT = 8'h0d;
  localparam logic [6:0] OP_STORE_ACC = 7'h37;
  // Data-space addresses of core registers reachable by the move.
  localparam logic [11:0] ADDR_ACC = 12'h0fe8;
  localparam logic [11:0] ADDR_PC_LOW = 12'h0ff9;
  localparam logic [11:0] ADDR_STACK_TOP_LOW = 12'h0ffd;
  localparam logic [11:0] ADDR_STACK_TOP_HIGH = 12'h0ffe;
  localparam logic [11:0] ADDR_STACK_TOP_UPPER = 12'h0fff;
  // Access bank split: low half maps to bank 0, high half to bank 15.
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'h0f;
  // Reset values.
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [7:0] RST_PROD = 8'h00;
  // Phase numbers within an instruction cycle.
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Data memory request.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dmm_mem_req_t;

  // Architectural state seen by the rest of the core.
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] bank;
    logic [7:0] prod_hi;
    logic [7:0] prod_lo;
  } dmm_arch_t;
endpackage

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dmm_pkg::*;
  logic sys_clk, reset_n, instr_valid, busy, instr_done;
  logic [1:0] phase;
  logic [15:0] instr;
  logic [7:0] mem_rdata;
  dmm_mem_req_t mem_req;
  dmm_arch_t arch;
  int errors, comparisons, n;
  dmm_decode dmm_decode_inst (.sys_clk(sys_clk), .reset_n(reset_n), .phase(phase),
    .instr(instr), .instr_valid(instr_valid), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .arch(arch), .busy(busy), .instr_done(instr_done));
  // Memory answers reads with an address-derived byte and noise otherwise.
  assign mem_rdata = mem_req.rd ? mem_req.addr[7:0] ^ 8'h5a : {6'h15, ~phase};
  // The phase count runs freely, one phase per clock, stepped on the edge so that
  // a task woken just after an edge sees the phase that the next edge samples.
  always @(posedge sys_clk) phase <= phase + 2'h1;
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  task op(input logic [15:0] w);
    while (phase !== PH_Q1) @(posedge sys_clk) #1;
    instr = w;
    instr_valid = 1'b1;
    @(posedge sys_clk) #1;
    instr_valid = 1'b0;
  endtask
  task mv(input logic [11:0] s, input logic [11:0] d);
    op({OP_MOVE_SRC, s});
    op({OP_MOVE_DST, d});
    n = 0;
    while (mem_req.wr !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk) #1;
      n++;
    end
  endtask
  task t_load;
    op({OP_LOAD_BANK, 8'ha5});
    chk("bank", 16'h01a5, {7'h0, instr_done, arch.bank});
    op({OP_LOAD_ACC, 8'he2});
    chk("acc", 16'h00e2, {8'h00, arch.acc});
    $display("load test ended");
  endtask
  task t_mul;
    logic [7:0] a [3] = '{8'he2, 8'hff, 8'h37};
    logic [7:0] k [3] = '{8'hc4, 8'hff, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      op({OP_LOAD_ACC, a[i]});
      op({OP_MUL_LIT, k[i]});
      chk("product", 16'(a[i]) * k[i], {arch.prod_hi, arch.prod_lo});
      chk("acc kept", {8'h00, a[i]}, {8'h00, arch.acc});
    end
    $display("multiply test ended");
  endtask
  task t_store;
    op({OP_LOAD_ACC, 8'h3c});
    op({OP_STORE_ACC, 9'h085});
    chk("store hi", 16'h1f85, {3'h0, mem_req.wr, mem_req.addr});
    chk("store data", 16'h003c, {8'h00, mem_req.wdata});
    op({OP_STORE_ACC, 9'h012});
    chk("store lo", 16'h0012, {4'h0, mem_req.addr});
    op({OP_STORE_ACC, 9'h112});
    chk("store bank", 16'h0512, {4'h0, mem_req.addr});
    $display("store test ended");
  endtask
  task t_move;
    op(16'hc123);
    chk("move read", 16'h1123, {3'h0, mem_req.rd, mem_req.addr});
    op(16'h0e11);
    op(16'hf456);
    n = 0;
    while (mem_req.wr !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk) #1;
      n++;
    end
    chk("write phase", 16'h0003, 16'(n));
    chk("move write", 16'h1456, {3'h0, mem_req.wr, mem_req.addr});
    chk("move data", 16'h0079, {8'h00, mem_req.wdata});
    chk("acc kept", 16'h003c, {8'h00, arch.acc});
    mv(12'h0a0, ADDR_ACC);
    chk("move to acc", 16'h00fa, {8'h00, arch.acc});
    mv(ADDR_ACC, 12'h7ff);
    chk("move from acc", 16'h00fa, {8'h00, mem_req.wdata});
    chk("move from acc addr", 16'h17ff, {3'h0, mem_req.wr, mem_req.addr});
    $display("move test ended");
  endtask
  initial
  begin
    errors = 0;
    comparisons = 0;
    phase = 2'h0;
    instr = 16'h0000;
    instr_valid = 1'b0;
    reset_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_load;
    t_mul;
    t_store;
    t_move;
    results;
  end
  // Cuts a hang short well past the hundred or so cycles the tests need.
  initial
  begin
    #200000;
    errors++;
    results;
  end
endmodule
`default_nettype wire
